/* File: verilog/aspwp_pkg.sv */
// constants, field layouts and carrier types for the audio word sample_merge/event block
// assumes a 16-bit register port and one system clock for all users
package aspwp_pkg;

    localparam int DW = 16;
    localparam int AW = 5;

    // register word offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_MASK = 5'h01;
    localparam logic [4:0] OFS_FLAG = 5'h02;
    localparam logic [4:0] OFS_RXL0 = 5'h04;
    localparam logic [4:0] OFS_RXL1 = 5'h05;
    localparam logic [4:0] OFS_RXR0 = 5'h06;
    localparam logic [4:0] OFS_RXR1 = 5'h07;
    localparam logic [4:0] OFS_TXL0 = 5'h08;
    localparam logic [4:0] OFS_TXL1 = 5'h09;
    localparam logic [4:0] OFS_TXR0 = 5'h0a;
    localparam logic [4:0] OFS_TXR1 = 5'h0b;

    // serializer control register fields
    localparam int CB_EN    = 0;
    localparam int CB_MONO  = 1;
    localparam int CB_FMT   = 2;
    localparam int CB_SIGN  = 3;
    localparam int CB_MERGE = 4;
    localparam int CB_WL    = 5;

    // word length codes and their bit counts
    localparam logic [2:0] WL_16 = 3'h0;
    localparam logic [2:0] WL_18 = 3'h1;
    localparam logic [2:0] WL_20 = 3'h2;
    localparam logic [2:0] WL_24 = 3'h3;
    localparam logic [2:0] WL_32 = 3'h4;
    localparam logic [5:0] WB_16 = 6'h10;
    localparam logic [5:0] WB_18 = 6'h12;
    localparam logic [5:0] WB_20 = 6'h14;
    localparam logic [5:0] WB_24 = 6'h18;
    localparam logic [5:0] WB_32 = 6'h20;

    // event flag and event mask fields
    localparam int FB_RX  = 0;
    localparam int FB_TX  = 1;
    localparam int FB_OVR = 2;
    localparam int FB_UND = 3;
    localparam int MB_SRX = 0;
    localparam int MB_STX = 1;
    localparam int MB_MRX = 2;
    localparam int MB_MTX = 3;
    localparam int MB_OVR = 4;
    localparam int MB_UND = 5;

    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [5:0]  MASK_RST = 6'h00;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} aspwp_fsm_t;

    typedef struct packed {
        logic            wr;
        logic            rd;
        logic [4:0]      addr;
        logic [15:0]     wdata;
    } aspwp_req_t;

    typedef struct packed {
        logic [15:0]       ctrl;
        logic [5:0]        mask;
        logic [3:0]        flag;
        logic [3:0][15:0]  rxd;
        logic [3:0][15:0]  txd;
        logic              rx_full;
        logic              tx_full;
        logic              first_done;
        logic              en_prev;
        aspwp_fsm_t        fsm;
        logic              chan;
        logic              half;
        logic              fsl;
        logic [5:0]        bitcnt;
        logic [31:0]       rxsh;
        logic [31:0]       txsh;
        logic [2:0]        sck;
        logic [2:0]        fsx;
        logic [1:0]        sd;
        logic              sdout;
        logic [15:0]       rdata;
        logic              irq;
        logic              dma_rx;
        logic              dma_tx;
        logic [1:0]        dma_eng;
    } aspwp_state_t;

endpackage

/* File: verilog/aspwp_top.sv */
// serial audio port: word packing, transfer events, errors, resets and idle
// assumes register port and config inputs on CLOCK; serial pins asynchronous
`timescale 1ns/1ps

module aspwp_top #(
    parameter int PORT_NUM = 0
) (
    // system clock and reset
    input  wire logic                CLOCK,
    input  wire logic                RST,
    // system control
    input  wire logic                SOFT_RST,
    input  wire logic                CLK_GATE,
    input  wire logic                BUS_SEL,
    // register port
    input  wire aspwp_pkg::aspwp_req_t REG_REQ,
    output logic [15:0]              REG_RDATA,
    // serial link
    input  wire logic                SCLK,
    input  wire logic                FSYNC,
    input  wire logic                SDIN,
    output logic                     SDOUT,
    // events
    output logic                     CPU_IRQ,
    output logic                     DMA_RX_EVT,
    output logic                     DMA_TX_EVT,
    output logic [1:0]               DMA_ENGINE
);

    function automatic logic [1:0] eng_of(input int p);
        case (p)
            1: return 2'h3;
            2: return 2'h1;
            3: return 2'h2;
            default: return 2'h0;
        endcase
    endfunction

    function automatic logic [5:0] wbits(input logic [2:0] c);
        case (c)
            aspwp_pkg::WL_18: return aspwp_pkg::WB_18;
            aspwp_pkg::WL_20: return aspwp_pkg::WB_20;
            aspwp_pkg::WL_24: return aspwp_pkg::WB_24;
            aspwp_pkg::WL_32: return aspwp_pkg::WB_32;
            default: return aspwp_pkg::WB_16;
        endcase
    endfunction

    // received word in low bits becomes {data 1, data 0}
    function automatic logic [31:0] sample_merge(input logic [31:0] s, input logic [5:0] w, input logic sf);
        logic [5:0]         sh;
        logic signed [31:0] t;
        sh = 6'h20 - w;
        t = s << sh;
        if (w == aspwp_pkg::WB_16) begin
            return {s[15:0], 16'h0000};
        end
        if (sf) begin
            return t >>> sh;
        end
        return t;
    endfunction

    // data register pair becomes a left-justified word for the shifter
    function automatic logic [31:0] txjust(input logic [15:0] d1, input logic [15:0] d0,
                                           input logic [5:0] w, input logic sf, input logic hf);
        if (w == aspwp_pkg::WB_16) begin
            return {hf ? d0 : d1, 16'h0000};
        end
        if (sf) begin
            return {d1, d0} << (6'h20 - w);
        end
        return {d1, d0};
    endfunction

    function automatic aspwp_pkg::aspwp_state_t rst_val();
        aspwp_pkg::aspwp_state_t s;
        s = '0;
        s.ctrl = aspwp_pkg::CTRL_RST;
        s.mask = aspwp_pkg::MASK_RST;
        s.fsm = aspwp_pkg::ST_IDLE;
        s.dma_eng = eng_of(PORT_NUM);
        return s;
    endfunction

    localparam aspwp_pkg::aspwp_state_t ST_RST = rst_val();

    aspwp_pkg::aspwp_state_t r;
    aspwp_pkg::aspwp_state_t n;
    logic [3:0]  set_f;
    logic [5:0]  w;
    logic [31:0] pk;
    logic        en;
    logic        mono;
    logic        fmt;
    logic        mg;
    logic        rise;
    logic        fall;
    logic        fs_now;
    logic        act;
    logic        start_l;
    logic        start_r;
    logic        wdone;
    logic        frame_ev;
    logic        tx_wr;
    logic        hold_half;

    assign w      = wbits(r.ctrl[aspwp_pkg::CB_WL +: 3]);
    assign en     = r.ctrl[aspwp_pkg::CB_EN];
    assign mono   = r.ctrl[aspwp_pkg::CB_MONO];
    assign fmt    = r.ctrl[aspwp_pkg::CB_FMT];
    assign mg     = r.ctrl[aspwp_pkg::CB_MERGE] & (w == aspwp_pkg::WB_16);
    assign hold_half = mg & r.half;
    // edges seen on the second and third stages only
    assign rise   = r.sck[1] & ~r.sck[2];
    assign fall   = ~r.sck[1] & r.sck[2];
    assign fs_now = r.fsx[1];
    assign act    = en & ~CLK_GATE & ~SOFT_RST & (r.fsm != aspwp_pkg::ST_IDLE);
    assign start_l = act & rise & (fmt ? (fs_now & ~r.fsl) : (~fs_now & r.fsl));
    assign start_r = act & rise & ~fmt & ~mono & fs_now & ~r.fsl;
    assign wdone  = act & rise & ~start_l & ~start_r & (r.fsm == aspwp_pkg::ST_RUN)
                  & (r.bitcnt == w - 6'h01);
    // only the last channel closes a frame; merge needs two frames
    assign frame_ev = wdone & (r.chan == ~mono) & (~mg | r.half);
    assign pk     = sample_merge({r.rxsh[30:0], r.sd[1]}, w, r.ctrl[aspwp_pkg::CB_SIGN]);
    assign tx_wr  = REG_REQ.wr & (REG_REQ.addr[4:2] == aspwp_pkg::OFS_TXL0[4:2]);

    always_comb begin
        n = r;
        set_f = 4'h0;
        n.sck = {r.sck[1:0], SCLK};
        n.fsx = {r.fsx[1:0], FSYNC};
        n.sd = {r.sd[0], SDIN};
        n.rdata = 16'h0000;
        n.irq = 1'b0;
        n.dma_rx = 1'b0;
        n.dma_tx = 1'b0;
        if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                aspwp_pkg::OFS_CTRL: begin
                    n.rdata = r.ctrl;
                end
                aspwp_pkg::OFS_MASK: begin
                    n.rdata = {10'h000, r.mask};
                end
                aspwp_pkg::OFS_FLAG: begin
                    n.rdata = {12'h000, r.flag};
                    n.flag = 4'h0;
                end
                aspwp_pkg::OFS_RXL0, aspwp_pkg::OFS_RXL1, aspwp_pkg::OFS_RXR0, aspwp_pkg::OFS_RXR1: begin
                    n.rdata = r.rxd[REG_REQ.addr[1:0]];
                    n.rx_full = 1'b0;
                end
                aspwp_pkg::OFS_TXL0, aspwp_pkg::OFS_TXL1, aspwp_pkg::OFS_TXR0, aspwp_pkg::OFS_TXR1: begin
                    n.rdata = r.txd[REG_REQ.addr[1:0]];
                end
                default: begin
                    n.rdata = 16'h0000;
                end
            endcase
        end
        if (REG_REQ.wr) begin
            case (REG_REQ.addr)
                aspwp_pkg::OFS_CTRL: begin
                    n.ctrl = REG_REQ.wdata;
                end
                aspwp_pkg::OFS_MASK: begin
                    n.mask = REG_REQ.wdata[5:0];
                end
                aspwp_pkg::OFS_TXL0, aspwp_pkg::OFS_TXL1, aspwp_pkg::OFS_TXR0, aspwp_pkg::OFS_TXR1: begin
                    n.txd[REG_REQ.addr[1:0]] = REG_REQ.wdata;
                    n.tx_full = 1'b1;
                end
                default: begin
                end
            endcase
        end
        n.en_prev = en;
        // harmless but visible: the first enable reports overrun and underrun where their mask bits are set
        if (en & ~r.en_prev & ~r.first_done) begin
            set_f[aspwp_pkg::FB_OVR] = r.mask[aspwp_pkg::MB_OVR];
            set_f[aspwp_pkg::FB_UND] = r.mask[aspwp_pkg::MB_UND];
            n.first_done = 1'b1;
        end
        if (!en) begin
            n.fsm = aspwp_pkg::ST_IDLE;
            n.half = 1'b0;
        end else begin
            if (r.fsm == aspwp_pkg::ST_IDLE) begin
                n.fsm = aspwp_pkg::ST_ARMED;
            end
            if (rise) begin
                n.fsl = fs_now;
            end
            if (start_l | start_r) begin
                n.fsm = aspwp_pkg::ST_RUN;
                n.chan = start_r;
                n.bitcnt = 6'h00;
                n.txsh = txjust(r.txd[{start_r, 1'b1}], r.txd[{start_r, 1'b0}], w,
                                r.ctrl[aspwp_pkg::CB_SIGN], hold_half);
                // no halt input: an unserviced frame simply underruns
                if (start_l & ~hold_half & ~r.tx_full) begin
                    set_f[aspwp_pkg::FB_UND] = r.mask[aspwp_pkg::MB_UND];
                end
            end else if (rise && r.fsm == aspwp_pkg::ST_RUN) begin
                n.rxsh = {r.rxsh[30:0], r.sd[1]};
                n.bitcnt = r.bitcnt + 6'h01;
                if (wdone) begin
                    if (mg) begin
                        if (r.half) begin
                            n.rxd[{r.chan, 1'b0}] = pk[31:16];
                        end else begin
                            n.rxd[{r.chan, 1'b1}] = pk[31:16];
                        end
                    end else begin
                        n.rxd[{r.chan, 1'b1}] = pk[31:16];
                        n.rxd[{r.chan, 1'b0}] = pk[15:0];
                    end
                    if (r.chan == ~mono) begin
                        n.fsm = aspwp_pkg::ST_ARMED;
                        if (mg) begin
                            n.half = ~r.half;
                        end
                    end else if (fmt) begin
                        // right word follows the left one directly
                        n.chan = 1'b1;
                        n.bitcnt = 6'h00;
                        n.txsh = txjust(r.txd[3], r.txd[2], w, r.ctrl[aspwp_pkg::CB_SIGN], hold_half);
                    end else begin
                        n.fsm = aspwp_pkg::ST_ARMED;
                    end
                end
            end else if (fall && r.fsm == aspwp_pkg::ST_RUN && act) begin
                n.sdout = r.txsh[31];
                n.txsh = {r.txsh[30:0], 1'b0};
            end
        end
        if (frame_ev) begin
            n.dma_rx = 1'b1;
            n.dma_tx = 1'b1;
            set_f[aspwp_pkg::FB_RX] = 1'b1;
            set_f[aspwp_pkg::FB_TX] = 1'b1;
            if (r.rx_full) begin
                set_f[aspwp_pkg::FB_OVR] = r.mask[aspwp_pkg::MB_OVR];
            end
            n.rx_full = 1'b1;
            n.tx_full = tx_wr;
        end
        // a new event beats a read-clear in the same cycle
        n.flag = n.flag | set_f;
        n.irq = ((set_f[aspwp_pkg::FB_RX] & (mono ? r.mask[aspwp_pkg::MB_MRX] : r.mask[aspwp_pkg::MB_SRX]))
               | (set_f[aspwp_pkg::FB_TX] & (mono ? r.mask[aspwp_pkg::MB_MTX] : r.mask[aspwp_pkg::MB_STX]))
               | set_f[aspwp_pkg::FB_OVR] | set_f[aspwp_pkg::FB_UND])
               & ((PORT_NUM > 1) | BUS_SEL);
        if (CLK_GATE) begin
            // idle: everything frozen, read data and pulses dropped, syncs keep sampling
            n = r;
            n.sck = {r.sck[1:0], SCLK};
            n.fsx = {r.fsx[1:0], FSYNC};
            n.sd = {r.sd[0], SDIN};
            n.rdata = 16'h0000;
            n.irq = 1'b0;
            n.dma_rx = 1'b0;
            n.dma_tx = 1'b0;
        end
        if (SOFT_RST) begin
            n = ST_RST;
            n.rxsh = r.rxsh;
            n.txsh = r.txsh;
            n.sck = {r.sck[1:0], SCLK};
            n.fsx = {r.fsx[1:0], FSYNC};
            n.sd = {r.sd[0], SDIN};
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            r <= ST_RST;
        end else begin
            r <= n;
        end
    end

    assign REG_RDATA  = r.rdata;
    assign SDOUT      = r.sdout;
    assign CPU_IRQ    = r.irq;
    assign DMA_RX_EVT = r.dma_rx;
    assign DMA_TX_EVT = r.dma_tx;
    assign DMA_ENGINE = r.dma_eng;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    sequence s_frame_end;
        frame_ev;
    endsequence

    sequence s_dma_pulse;
        DMA_RX_EVT && DMA_TX_EVT ##1 !DMA_RX_EVT && !DMA_TX_EVT;
    endsequence

    a_dma_frame_pulse: assert property (s_frame_end |=> s_dma_pulse)
        else $error("dma events not a single pulse after frame");

    a_irq_one_cycle: assert property (CPU_IRQ |=> !CPU_IRQ)
        else $error("cpu interrupt longer than one cycle");

    a_stereo_right_last: assert property (frame_ev && !mono |-> r.chan == 1'b1)
        else $error("stereo frame ended on left channel");

    a_mono_left_only: assert property (DMA_RX_EVT && $past(mono) |-> $past(r.chan) == 1'b0)
        else $error("mono event not after left word");

    a_irq_bus_gate: assert property (CPU_IRQ && PORT_NUM < 2 |-> $past(BUS_SEL))
        else $error("interrupt reached cpu without bus selection");

    a_flag_set_wins: assert property (frame_ev && REG_REQ.rd && REG_REQ.addr == aspwp_pkg::OFS_FLAG
                                      |=> r.flag[aspwp_pkg::FB_RX] && r.flag[aspwp_pkg::FB_TX])
        else $error("flag event lost against read clear");

    a_soft_keeps_shift: assert property (SOFT_RST |=> r.rxsh == $past(r.rxsh) && r.ctrl == 16'h0000
                                         && r.flag == 4'h0)
        else $error("soft reset wrong on shifter or registers");

    a_idle_holds: assert property (CLK_GATE && !SOFT_RST |=> $stable(r.ctrl) && $stable(r.flag)
                                   && !DMA_RX_EVT && !CPU_IRQ)
        else $error("state changed while clock gated");

    a_sample_merge_16_zero: assert property (wdone && w == aspwp_pkg::WB_16 && !mg
                                     |=> r.rxd[{$past(r.chan), 1'b0}] == 16'h0000)
        else $error("16-bit data 0 not zero");

    a_first_error: assert property (en && !r.en_prev && !r.first_done && r.mask[aspwp_pkg::MB_OVR]
                                    && !CLK_GATE && !SOFT_RST |=> r.flag[aspwp_pkg::FB_OVR] ##1 r.first_done)
        else $error("first enable did not flag error");

    a_dma_engine: assert property (DMA_ENGINE == eng_of(PORT_NUM))
        else $error("wrong dma engine for port");

    // overrun: a frame ends while the previous one is still unread
    a_rx_overrun: assert property (frame_ev && r.rx_full && r.mask[aspwp_pkg::MB_OVR]
                                   |=> r.flag[aspwp_pkg::FB_OVR])
        else $error("overrun not flagged");

    // dma must not depend on any mask bit
    a_dma_ignores_mask: assert property (frame_ev && r.mask == 6'h00 |=> DMA_RX_EVT && DMA_TX_EVT)
        else $error("dma event held back by mask");

endmodule

/* File: verification/aspwp_codec_model.sv */
// external converter model: frame master making bit clock, frame sync and serial data
// assumes DSP frame format; the bit clock stands still low between frames
`timescale 1ns/1ps

module aspwp_codec_model #(
    parameter real HALF = 62.5
) (
    // serial link
    output logic      sclk,
    output logic      fsync,
    output logic      sdin,
    input  wire logic sdout
);
    logic [31:0] cap_l;
    logic [31:0] cap_r;

    initial begin
        sclk  = 1'b0;
        fsync = 1'b0;
        sdin  = 1'b0;
    end

    // sync pulse seen at one rise, then left word, right word unless mono
    task automatic frame(input int w, input logic mono, input logic [31:0] l, input logic [31:0] r);
        logic [31:0] x;
        fsync = 1'b1;
        #HALF sclk = 1'b1;
        #HALF sclk = 1'b0;
        fsync = 1'b0;
        for (int ch = 0; ch < (mono ? 1 : 2); ch++) begin
            x = (ch == 0) ? l : r;
            for (int i = w - 1; i >= 0; i--) begin
                sdin = x[i];
                #HALF sclk = 1'b1;
                if (ch == 0) cap_l = {cap_l[30:0], sdout};
                else cap_r = {cap_r[30:0], sdout};
                #HALF sclk = 1'b0;
            end
        end
        // released line shows the inverse, so a late sample is caught
        sdin = ~sdin;
    endtask
endmodule

/* File: verification/aspwp_top_tb.sv */
// bench for the audio word sample_merge/event block: register tasks, codec frames, event counts
// assumes the codec model is the frame master and DSP frame format throughout
`timescale 1ns/1ps

module aspwp_top_tb;
    localparam logic [31:0] TL = 32'h5a3c9ef1;
    localparam logic [31:0] TR = 32'hc3a5e10f;
    localparam logic [31:0] RL = 32'hd16aee09;
    localparam logic [31:0] RR = 32'h98a31157;
    logic                  clock;
    logic                  rst;
    logic                  soft_rst;
    logic                  clk_gate;
    logic                  bus_sel;
    aspwp_pkg::aspwp_req_t req;
    logic [15:0]           rdata;
    logic                  sclk;
    logic                  fsync;
    logic                  sdin;
    logic                  sdout;
    logic                  cpu_irq;
    logic                  dma_rx;
    logic                  dma_tx;
    wire [3:0][1:0]        eng;
    int                    bad_count;
    int                    n_compared;
    int                    n_rx;
    int                    n_tx;
    int                    n_irq;
    logic [31:0]           p;
    int                    w;
    logic                  sf;
    logic [15:0]           e;
    int                    wls[5] = '{16, 18, 20, 24, 32};
    // ctrl byte, mask, bus select, irq expected
    logic [15:0]           tab[7] = '{16'h0507, 16'h0532, 16'h0502, 16'h0713, 16'h0710, 16'h0706, 16'h0406};
    logic [1:0]            engx[4] = '{2'h0, 2'h3, 2'h1, 2'h2};

    aspwp_top uut (.CLOCK(clock), .RST(rst), .SOFT_RST(soft_rst), .CLK_GATE(clk_gate), .BUS_SEL(bus_sel),
        .REG_REQ(req), .REG_RDATA(rdata), .SCLK(sclk), .FSYNC(fsync), .SDIN(sdin), .SDOUT(sdout),
        .CPU_IRQ(cpu_irq), .DMA_RX_EVT(dma_rx), .DMA_TX_EVT(dma_tx), .DMA_ENGINE(eng[0]));
    for (genvar g = 1; g < 4; g++) begin : g_port
        aspwp_top #(.PORT_NUM(g)) u_port (.CLOCK(clock), .RST(rst), .SOFT_RST(soft_rst), .CLK_GATE(clk_gate),
            .BUS_SEL(bus_sel), .REG_REQ(req), .REG_RDATA(), .SCLK(sclk), .FSYNC(fsync), .SDIN(sdin),
            .SDOUT(), .CPU_IRQ(), .DMA_RX_EVT(), .DMA_TX_EVT(), .DMA_ENGINE(eng[g]));
    end
    aspwp_codec_model codec (.sclk(sclk), .fsync(fsync), .sdin(sdin), .sdout(sdout));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // high cycles are counted, so a stretched pulse shows as an extra event
    always @(posedge clock) begin
        if (dma_rx === 1'b1) n_rx++;
        if (dma_tx === 1'b1) n_tx++;
        if (cpu_irq === 1'b1) n_irq++;
    end

    function automatic logic [31:0] msk(input int w, input logic [31:0] x);
        return (w == 32) ? x : (x & ((32'h1 << w) - 32'h1));
    endfunction

    function automatic logic [31:0] pk(input int w, input logic sf, input logic [31:0] x);
        logic [31:0] m;
        m = msk(w, x);
        if (w == 16) return {m[15:0], 16'h0000};
        if (sf) return 32'($signed(m << (32 - w)) >>> (32 - w));
        return m << (32 - w);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clock);
        req.wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp, input string what);
        @(posedge clock);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clock);
        req.rd <= 1'b0;
        @(negedge clock);
        check(what, {16'h0000, rdata}, {16'h0000, exp});
    endtask

    // frame edges kept off the clock edges so the synchronisers never race
    task automatic fr(input int w, input logic mono, input logic [31:0] l, input logic [31:0] r);
        @(negedge clock);
        n_rx = 0;
        n_tx = 0;
        n_irq = 0;
        #1;
        codec.frame(w, mono, l, r);
        repeat (12) @(posedge clock);
    endtask

    task automatic evchk(input int er, input int ei);
        check("dma rx events", 32'(n_rx), 32'(er));
        check("dma tx events", 32'(n_tx), 32'(er));
        check("cpu irq events", 32'(n_irq), 32'(ei));
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #450000;
        bad_count++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        stop_test;
    end

    initial begin
        rst = 1'b1;
        soft_rst = 1'b0;
        clk_gate = 1'b0;
        bus_sel = 1'b1;
        req = '0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rdchk(5'h00, 16'h0000, "ctrl reset");
        rdchk(5'h02, 16'h0000, "flag reset");
        rdchk(5'h1f, 16'h0000, "unmapped read");
        for (int i = 0; i < 4; i++) check("dma engine", 32'(eng[i]), 32'(engx[i]));
        $display("test reset values done");
        wr(5'h01, 16'h0030);
        wr(5'h00, 16'h0005);
        repeat (20) @(posedge clock);
        rdchk(5'h02, 16'h000c, "first enable error");
        rdchk(5'h02, 16'h0000, "flag read clears");
        for (int i = 0; i < 4; i++) wr(5'h08 + 5'(i), 16'h1234);
        fr(16, 1'b0, RL, RR);
        rdchk(5'h02, 16'h0003, "data flags");
        fr(16, 1'b0, RL, RR);
        rdchk(5'h02, 16'h000f, "unserviced errors");
        $display("test error flags done");
        wr(5'h01, 16'h0000);
        for (int k = 0; k < 10; k++) begin
            w = wls[k / 2];
            sf = 1'(k % 2);
            wr(5'h00, {8'h00, 3'(k / 2), 1'b0, sf, 3'h5});
            p = pk(w, sf, TL);
            wr(5'h09, p[31:16]);
            wr(5'h08, p[15:0]);
            p = pk(w, sf, TR);
            wr(5'h0b, p[31:16]);
            wr(5'h0a, p[15:0]);
            fr(w, 1'b0, RL, RR);
            evchk(1, 0);
            p = pk(w, sf, RL);
            rdchk(5'h05, p[31:16], "rx left data 1");
            rdchk(5'h04, p[15:0], "rx left data 0");
            p = pk(w, sf, RR);
            rdchk(5'h07, p[31:16], "rx right data 1");
            rdchk(5'h06, p[15:0], "rx right data 0");
            check("tx left word", msk(w, codec.cap_l), msk(w, TL));
            check("tx right word", msk(w, codec.cap_r), msk(w, TR));
        end
        $display("test word layouts done");
        wr(5'h00, 16'h0015);
        fr(16, 1'b0, RL, RR);
        evchk(0, 0);
        fr(16, 1'b0, TL, TR);
        evchk(1, 0);
        rdchk(5'h05, RL[15:0], "merged left older");
        rdchk(5'h04, TL[15:0], "merged left newer");
        rdchk(5'h06, TR[15:0], "merged right newer");
        $display("test sample merge done");
        for (int i = 0; i < 7; i++) begin
            e = tab[i];
            @(posedge clock);
            bus_sel <= e[1];
            wr(5'h01, {10'h000, e[7:2]});
            wr(5'h00, {8'h00, e[15:8]});
            fr(16, e[9], RL, RR);
            evchk(int'(e[8]), int'(e[0]));
        end
        $display("test event modes done");
        @(posedge clock);
        rst <= 1'b1;
        @(negedge clock);
        check("dma engine in reset", 32'(eng[0]), 32'(engx[0]));
        @(posedge clock);
        rst <= 1'b0;
        rdchk(5'h01, 16'h0000, "mask after reset");
        rdchk(5'h05, 16'h0000, "rx data after reset");
        $display("test hard reset done");
        wr(5'h00, 16'h0005);
        wr(5'h01, 16'h0031);
        @(posedge clock);
        soft_rst <= 1'b1;
        @(posedge clock);
        soft_rst <= 1'b0;
        rdchk(5'h00, 16'h0000, "ctrl after soft reset");
        rdchk(5'h01, 16'h0000, "mask after soft reset");
        $display("test soft reset done");
        wr(5'h00, 16'h0005);
        @(posedge clock);
        clk_gate <= 1'b1;
        wr(5'h00, 16'h0000);
        rdchk(5'h00, 16'h0000, "read while idle");
        fr(16, 1'b0, RL, RR);
        evchk(0, 0);
        @(posedge clock);
        clk_gate <= 1'b0;
        rdchk(5'h00, 16'h0005, "ctrl kept over idle");
        $display("test idle done");
        stop_test;
    end
endmodule
